//--- hdl/lrbd_pkg.sv
// shared constants for the lookup-table memory unit and its routing cell
package lrbd_pkg;
    // memory organisation
    localparam int ADDR_W = 5;
    localparam int DATA_W = 4;
    localparam int DEPTH = 32;
    localparam int BIT_COUNT = 128;
    localparam int LOOKUP_W = 4;
    localparam int DIRECT_W = 8;

    // direct input positions: write address on odd pins, data on even pins (msb first)
    localparam int WADDR_PIN3 = 7;
    localparam int WADDR_PIN2 = 5;
    localparam int WADDR_PIN1 = 3;
    localparam int WADDR_PIN0 = 1;
    localparam int WDATA_PIN3 = 6;
    localparam int WDATA_PIN2 = 4;
    localparam int WDATA_PIN1 = 2;
    localparam int WDATA_PIN0 = 0;

    // routing cell layout: two nibble groups and one control pair
    localparam int BIDIR_BUFFER_W = 10;
    localparam int GROUPS = 3;
    localparam int NIB0_LO = 0;
    localparam int NIB1_LO = 4;
    localparam int PAIR_LO = 8;
    localparam int NIB_W = 4;
    localparam int PAIR_W = 2;

    // direction control bits per group
    localparam int DIR_TO_RIGHT = 0;
    localparam int DIR_TO_LEFT = 1;
    localparam int DIR_CENTRAL = 2;

    // mode codes: code + 1 is the printed mode number; bit set = group decodes
    localparam logic [2:0] MODE_BUFFER = 3'h0;
    localparam logic [2:0] MODE_DECODER = 3'h7;
    localparam int MODE_BIT_NIB0 = 2;
    localparam int MODE_BIT_NIB1 = 1;
    localparam int MODE_BIT_PAIR = 0;

    // unit clock synchroniser reset level
    localparam logic SYNC_RST = 1'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
endpackage

//--- hdl/lrbd_routing_cell.sv
// routing logic cell: ten bidirectional buffers plus and/or decoder
module lrbd_routing_cell (
    input wire logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] leftSideInput,
    input wire logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] rightSideInput,
    input wire logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] centralInput,
    input wire logic [2:0] modeSel,
    input wire logic [lrbd_pkg::GROUPS-1:0][2:0] bufDirCfg,
    input wire logic triInput,
    input wire logic [1:0] triInvert,
    input wire logic [1:0] triDisable,
    input wire logic [1:0] nibbleTriFromDec,
    input wire logic andOrSel,
    input wire logic decInvert,
    input wire logic gateDecWithTri,
    input wire logic constLevel,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] leftSideOutput,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] leftSideOutputEn,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] rightSideOutput,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] rightSideOutputEn,
    output logic decoderOutput
);
    logic [2:0] isDec;
    logic [2:0] andTerm;
    logic [2:0] gateIn;
    logic decRaw;
    logic [2:0] grpEn;

    // mode decode: each group buffer or decoder independently
    assign isDec[0] = modeSel[lrbd_pkg::MODE_BIT_NIB0];
    assign isDec[1] = modeSel[lrbd_pkg::MODE_BIT_NIB1];
    assign isDec[2] = modeSel[lrbd_pkg::MODE_BIT_PAIR];

    assign andTerm[0] = &centralInput[lrbd_pkg::NIB0_LO +: lrbd_pkg::NIB_W];
    assign andTerm[1] = &centralInput[lrbd_pkg::NIB1_LO +: lrbd_pkg::NIB_W];
    assign andTerm[2] = &centralInput[lrbd_pkg::PAIR_LO +: lrbd_pkg::PAIR_W];

    // three-input gate; a buffering group offers the neutral level
    always_comb begin
        for (int g = 0; g < lrbd_pkg::GROUPS; g++) begin
            gateIn[g] = isDec[g] ? andTerm[g] : andOrSel;
        end
        decRaw = andOrSel ? (&gateIn) : (|gateIn);
    end

    // all-buffer mode gives a constant level; optional tri gating
    always_comb begin
        if (modeSel == lrbd_pkg::MODE_BUFFER) begin
            decoderOutput = constLevel;
        end else if (gateDecWithTri && (modeSel != lrbd_pkg::MODE_DECODER)) begin
            decoderOutput = (decRaw ^ decInvert) & triInput;
        end else begin
            decoderOutput = decRaw ^ decInvert;
        end
    end

    // shared tri control, decoder may steer one nibble instead
    always_comb begin
        for (int g = 0; g < 2; g++) begin
            if (isDec[g]) begin
                grpEn[g] = 1'b0;
            end else if (nibbleTriFromDec[g]) begin
                grpEn[g] = decoderOutput;
            end else if (triDisable[g]) begin
                grpEn[g] = 1'b1;
            end else begin
                grpEn[g] = triInput ^ triInvert[g];
            end
        end
        // pair group cannot float, only decoder use turns it off
        grpEn[2] = ~isDec[2];
    end

    // per-group direction: left to right, right to left, or centre outward
    genvar b;
    generate
        for (b = 0; b < lrbd_pkg::BIDIR_BUFFER_W; b++) begin : g_bidir_buffer
            localparam int GRP = (b < lrbd_pkg::NIB1_LO) ? 0 : ((b < lrbd_pkg::PAIR_LO) ? 1 : 2);
            logic central;
            assign central = bufDirCfg[GRP][lrbd_pkg::DIR_CENTRAL];
            assign rightSideOutput[b] = central ? centralInput[b] : leftSideInput[b];
            assign leftSideOutput[b] = central ? centralInput[b] : rightSideInput[b];
            assign rightSideOutputEn[b] = grpEn[GRP] & bufDirCfg[GRP][lrbd_pkg::DIR_TO_RIGHT];
            assign leftSideOutputEn[b] = grpEn[GRP] & bufDirCfg[GRP][lrbd_pkg::DIR_TO_LEFT];
        end
    endgenerate
endmodule

//--- hdl/lrbd_logic_tile.sv
// logic tile: 32x4 dual-port lookup memory with routing cell for bank select
// What this block does
// - logic unit acts as a 32-word by 4-bit dual-port memory, 128 bits.
// - read address: four lookup inputs low bits, wide-select input is msb.
// - write address: carry input msb, then direct inputs 7,5,3,1 down to lsb.
// - write data on direct inputs 6,4,2,0, input 6 most significant.
// - read data combinational on lookup outputs, registered copy on storage outputs.
// - one write strobe plus two write-port enables control writing.
// - clock, strobe and port-enable polarities configurable; port enables can be disabled.
// - active edge captures data, address, enable; opposite edge writes the array.
// - read port is asynchronous yet safe for write-then-read use.
// - with writes off and contents preloaded the memory is a read-only table.
// - upper write-address bits drive port enables to pick one of four banks.
// - two read-address bits decoded in routing cell enable read-data drivers.
// - optional read enable floats the read-data bus while inactive.
// - ten bidirectional buffers in groups 4,4,2, each with selectable direction.
// - only the two nibble groups can float; the pair group cannot.
// - one shared tri control, invertible or disabled per nibble group.
// - decoder output may float one nibble while shared control drives the other.
// - in all-buffer mode the decoder output is a constant high or low.
// - group and-gates feed a three-input and/or gate, optionally inverted.
// - decoder output may be gated by tri input to enable up to eight buffers.
// - eight modes, each group independently buffer or decoder.
module lrbd_logic_tile #(
    parameter logic [lrbd_pkg::BIT_COUNT-1:0] INIT_CONTENT = 128'h0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic unitClk,
    input wire logic [lrbd_pkg::LOOKUP_W-1:0] lookupInput,
    input wire logic wideSelectInput,
    input wire logic carryInput,
    input wire logic [lrbd_pkg::DIRECT_W-1:0] directInput,
    input wire logic writeStrobeInput,
    input wire logic portEnableA,
    input wire logic portEnableB,
    input wire logic invClk,
    input wire logic invWriteStrobe,
    input wire logic invPortEnableA,
    input wire logic invPortEnableB,
    input wire logic usePortEnableA,
    input wire logic usePortEnableB,
    input wire logic romMode,
    input wire logic [1:0] bankReadAddr,
    input wire logic [lrbd_pkg::NIB_W-1:0] auxNibbleIn,
    input wire logic readEnable,
    input wire logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] leftSideInput,
    input wire logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] rightSideInput,
    input wire logic [2:0] modeSel,
    input wire logic [lrbd_pkg::GROUPS-1:0][2:0] bufDirCfg,
    input wire logic [1:0] triInvert,
    input wire logic [1:0] triDisable,
    input wire logic [1:0] nibbleTriFromDec,
    input wire logic andOrSel,
    input wire logic decInvert,
    input wire logic gateDecWithTri,
    input wire logic constLevel,
    output logic [lrbd_pkg::DATA_W-1:0] lookupOutputEven,
    output logic [lrbd_pkg::DATA_W-1:0] storageOutputEven,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] leftSideOutput,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] leftSideOutputEn,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] rightSideOutput,
    output logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] rightSideOutputEn,
    output logic decoderOutput
);
    logic [lrbd_pkg::DATA_W-1:0] memArray [lrbd_pkg::DEPTH];
    logic ucS1_q;
    logic ucS2_q;
    logic ucPrev_q;
    logic edgeRise;
    logic edgeFall;
    logic activeEdge;
    logic oppEdge;
    logic [lrbd_pkg::ADDR_W-1:0] rdAddr;
    logic [lrbd_pkg::ADDR_W-1:0] wrAddrCur;
    logic [lrbd_pkg::DATA_W-1:0] wrDataCur;
    logic writeOk;
    logic [lrbd_pkg::ADDR_W-1:0] wrAddr_q;
    logic [lrbd_pkg::DATA_W-1:0] wrData_q;
    logic wrEn_q;
    logic [lrbd_pkg::DATA_W-1:0] readData;
    logic [lrbd_pkg::DATA_W-1:0] storage_q;
    logic [lrbd_pkg::BIDIR_BUFFER_W-1:0] centralBus;

    // unit clock comes from outside logic as a pin, so it is synchronised first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ucS1_q <= lrbd_pkg::SYNC_RST;
            ucS2_q <= lrbd_pkg::SYNC_RST;
            ucPrev_q <= lrbd_pkg::SYNC_RST;
        end else begin
            ucS1_q <= unitClk;
            ucS2_q <= ucS1_q;
            ucPrev_q <= ucS2_q;
        end
    end

    // clock polarity picks which edge is the active one
    assign edgeRise = ucS2_q & ~ucPrev_q;
    assign edgeFall = ~ucS2_q & ucPrev_q;
    assign activeEdge = invClk ? edgeFall : edgeRise;
    assign oppEdge = invClk ? edgeRise : edgeFall;

    assign rdAddr = {wideSelectInput, lookupInput};
    // write address from carry input and odd direct inputs
    assign wrAddrCur = {carryInput, directInput[lrbd_pkg::WADDR_PIN3], directInput[lrbd_pkg::WADDR_PIN2],
                        directInput[lrbd_pkg::WADDR_PIN1], directInput[lrbd_pkg::WADDR_PIN0]};
    // write data from even direct inputs
    assign wrDataCur = {directInput[lrbd_pkg::WDATA_PIN3], directInput[lrbd_pkg::WDATA_PIN2],
                        directInput[lrbd_pkg::WDATA_PIN1], directInput[lrbd_pkg::WDATA_PIN0]};

    // one strobe plus two port enables gate writing
    // strobe and each enabled port enable must be active; bank pick rides on these
    // read-only table ignores every write input
    assign writeOk = ~romMode
                     & (writeStrobeInput ^ invWriteStrobe)
                     & (~usePortEnableA | (portEnableA ^ invPortEnableA))
                     & (~usePortEnableB | (portEnableB ^ invPortEnableB));

    // capture stage on the active edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrAddr_q <= lrbd_pkg::ADDR_RST;
            wrData_q <= lrbd_pkg::DATA_RST;
            wrEn_q <= 1'b0;
        end else if (activeEdge) begin
            wrAddr_q <= wrAddrCur;
            wrData_q <= wrDataCur;
            wrEn_q <= writeOk;
        end
    end

    // array update half a unit-clock cycle later; 32x4 storage
    // reset reloads the configuration contents, a constant, so it stays legal under async reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < lrbd_pkg::DEPTH; i++) begin
                memArray[i] <= INIT_CONTENT[i*lrbd_pkg::DATA_W +: lrbd_pkg::DATA_W];
            end
        end else if (oppEdge && wrEn_q) begin
            memArray[wrAddr_q] <= wrData_q;
        end
    end

    assign readData = memArray[rdAddr];
    assign lookupOutputEven = readData;

    // registered read copy on the active edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            storage_q <= lrbd_pkg::DATA_RST;
        end else if (activeEdge) begin
            storage_q <= readData;
        end
    end
    assign storageOutputEven = storage_q;

    // read data on nibble 0, bank read address on the decoding pair
    assign centralBus = {bankReadAddr, auxNibbleIn, readData};

    // read enable is the shared tri control for the read-data drivers
    lrbd_routing_cell u_routing (
        .leftSideInput(leftSideInput),
        .rightSideInput(rightSideInput),
        .centralInput(centralBus),
        .modeSel(modeSel),
        .bufDirCfg(bufDirCfg),
        .triInput(readEnable),
        .triInvert(triInvert),
        .triDisable(triDisable),
        .nibbleTriFromDec(nibbleTriFromDec),
        .andOrSel(andOrSel),
        .decInvert(decInvert),
        .gateDecWithTri(gateDecWithTri),
        .constLevel(constLevel),
        .leftSideOutput(leftSideOutput),
        .leftSideOutputEn(leftSideOutputEn),
        .rightSideOutput(rightSideOutput),
        .rightSideOutputEn(rightSideOutputEn),
        .decoderOutput(decoderOutput)
    );

    // checks on capture, write, read and routing behaviour
    property p_capture;
        @(posedge clk_sys) disable iff (!rst_n)
        activeEdge && writeOk |=> wrEn_q && (wrAddr_q == $past(wrAddrCur)) && (wrData_q == $past(wrDataCur));
    endproperty
    a_capture: assert property (p_capture) else $error("write capture missed");

    property p_arrayWrite;
        @(posedge clk_sys) disable iff (!rst_n)
        oppEdge && wrEn_q |=> memArray[$past(wrAddr_q)] == $past(wrData_q);
    endproperty
    a_arrayWrite: assert property (p_arrayWrite) else $error("array not updated on opposite edge");

    property p_romIgnores;
        @(posedge clk_sys) disable iff (!rst_n)
        romMode && activeEdge |=> !wrEn_q;
    endproperty
    a_romIgnores: assert property (p_romIgnores) else $error("write armed in read-only mode");

    property p_portGate;
        @(posedge clk_sys) disable iff (!rst_n)
        activeEdge && usePortEnableA && (portEnableA == invPortEnableA) |=> !wrEn_q;
    endproperty
    a_portGate: assert property (p_portGate) else $error("inactive port enable allowed a write");

    property p_asyncRead;
        @(posedge clk_sys) disable iff (!rst_n)
        oppEdge && wrEn_q && (rdAddr == wrAddr_q)
            |=> (rdAddr != $past(rdAddr)) || (lookupOutputEven == $past(wrData_q));
    endproperty
    a_asyncRead: assert property (p_asyncRead) else $error("combinational read mismatch");

    property p_regRead;
        @(posedge clk_sys) disable iff (!rst_n)
        activeEdge ##1 !activeEdge[*2] |-> storageOutputEven == $past(readData, 2);
    endproperty
    a_regRead: assert property (p_regRead) else $error("registered read copy wrong");

    property p_readFloat;
        @(posedge clk_sys) disable iff (!rst_n)
        !readEnable && !triDisable[0] && !triInvert[0] && !nibbleTriFromDec[0]
            |-> (leftSideOutputEn[3:0] == 4'h0) && (rightSideOutputEn[3:0] == 4'h0);
    endproperty
    a_readFloat: assert property (p_readFloat) else $error("read bus driven while disabled");

    property p_pairNoFloat;
        @(posedge clk_sys) disable iff (!rst_n)
        !modeSel[lrbd_pkg::MODE_BIT_PAIR] && bufDirCfg[2][lrbd_pkg::DIR_TO_RIGHT]
            |-> rightSideOutputEn[9:8] == 2'h3;
    endproperty
    a_pairNoFloat: assert property (p_pairNoFloat) else $error("pair group floated");

    property p_constDec;
        @(posedge clk_sys) disable iff (!rst_n)
        modeSel == lrbd_pkg::MODE_BUFFER |-> decoderOutput == constLevel;
    endproperty
    a_constDec: assert property (p_constDec) else $error("constant decoder level wrong");

    // an inactive strobe must leave the capture disarmed
    property p_strobeGate;
        @(posedge clk_sys) disable iff (!rst_n)
        activeEdge && (writeStrobeInput == invWriteStrobe) |=> !wrEn_q;
    endproperty
    a_strobeGate: assert property (p_strobeGate) else $error("inactive write strobe allowed a write");

    // a bank whose second port enable is off must not accept the word
    property p_bankGate;
        @(posedge clk_sys) disable iff (!rst_n)
        activeEdge && usePortEnableB && (portEnableB == invPortEnableB) |=> !wrEn_q;
    endproperty
    a_bankGate: assert property (p_bankGate) else $error("unselected bank accepted a write");

    // the registered copy moves only on an active unit clock edge
    property p_regHold;
        @(posedge clk_sys) disable iff (!rst_n)
        !activeEdge |=> $stable(storageOutputEven);
    endproperty
    a_regHold: assert property (p_regHold) else $error("registered read copy moved off its edge");

    // a nibble steered by the decoder follows the decoder output
    property p_nibbleFromDec;
        @(posedge clk_sys) disable iff (!rst_n)
        nibbleTriFromDec[1] && !modeSel[lrbd_pkg::MODE_BIT_NIB1] && bufDirCfg[1][lrbd_pkg::DIR_TO_RIGHT]
            |-> rightSideOutputEn[7:4] == {4{decoderOutput}};
    endproperty
    a_nibbleFromDec: assert property (p_nibbleFromDec) else $error("decoder did not steer nibble one");
endmodule

//--- dv/lrbd_user_model.sv
// user-side write driver for the lookup memory: unit clock, write address, data and enables
module lrbd_user_model (
    input wire logic clk_sys,
    input wire logic invClk,
    output logic unitClk,
    output logic carryInput,
    output logic [lrbd_pkg::DIRECT_W-1:0] directInput,
    output logic writeStrobeInput,
    output logic portEnableA,
    output logic portEnableB
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clkPhase;
    // unit clock idles at its inactive level, so the first change is always the active edge
    assign unitClk = clkPhase ^ invClk;
    initial begin
        clkPhase = 1'b0;
        {carryInput, directInput, writeStrobeInput, portEnableA, portEnableB} = 12'h000;
    end
    // one address and control set would fan out to every slice of a wider word
    // address, data, strobe and port enables
    task automatic writeBegin(input logic [4:0] addr, input logic [3:0] data, input logic [2:0] en);
        @(negedge clk_sys);
        carryInput = addr[4];
        directInput = {addr[3], data[3], addr[2], data[2], addr[1], data[1], addr[0], data[0]};
        {writeStrobeInput, portEnableA, portEnableB} = en;
        clkPhase = 1'b1;
        // phases of at least three system cycles keep the edge detector honest
        repeat (4) @(negedge clk_sys);
    endtask
    // opposite edge, then hold through the deferred array update
    task automatic writeEnd();
        clkPhase = 1'b0;
        repeat (5) @(negedge clk_sys);
        // released lines show the inverse so stale values cannot pass for a hold
        carryInput = ~carryInput;
        directInput = ~directInput;
    endtask
endmodule

//--- dv/tb_lrbd_logic_tile.sv
// self-checking bench for the lookup memory tile and its routing cell
module tb_lrbd_logic_tile;
    timeunit 1ns;
    timeprecision 1ps;
    // preload pattern, word i in bits 4i+3:4i
    localparam logic [127:0] INIT = 128'hFEDCBA98765432100123456789ABCDEF;
    logic clk_sys, rst_n, unitClk, wideSelectInput, carryInput, writeStrobeInput, portEnableA, portEnableB;
    logic invClk, invWriteStrobe, invPortEnableA, invPortEnableB, usePortEnableA, usePortEnableB, romMode;
    logic readEnable, andOrSel, decInvert, gateDecWithTri, constLevel, decoderOutput;
    logic [3:0] lookupInput, auxNibbleIn, lookupOutputEven, storageOutputEven;
    logic [7:0] directInput;
    logic [1:0] bankReadAddr, triInvert, triDisable, nibbleTriFromDec;
    logic [9:0] leftSideInput, rightSideInput, leftSideOutput, leftSideOutputEn;
    logic [9:0] rightSideOutput, rightSideOutputEn;
    logic [2:0] modeSel;
    logic [lrbd_pkg::GROUPS-1:0][2:0] bufDirCfg;
    logic [3:0] mem [32];
    logic [9:0] cases [8];
    logic [6:0] decTab [6];
    int badCount = 0;
    int testsRun = 0;

    always #12.5 clk_sys = ~clk_sys;

    lrbd_user_model uPart (.clk_sys, .invClk, .unitClk, .carryInput, .directInput, .writeStrobeInput,
        .portEnableA, .portEnableB);
    lrbd_logic_tile #(.INIT_CONTENT(INIT)) uut (.clk_sys, .rst_n, .unitClk, .lookupInput, .wideSelectInput,
        .carryInput, .directInput, .writeStrobeInput, .portEnableA, .portEnableB, .invClk, .invWriteStrobe,
        .invPortEnableA, .invPortEnableB, .usePortEnableA, .usePortEnableB, .romMode, .bankReadAddr,
        .auxNibbleIn, .readEnable, .leftSideInput, .rightSideInput, .modeSel, .bufDirCfg, .triInvert,
        .triDisable, .nibbleTriFromDec, .andOrSel, .decInvert, .gateDecWithTri, .constLevel,
        .lookupOutputEven, .storageOutputEven, .leftSideOutput, .leftSideOutputEn, .rightSideOutput,
        .rightSideOutputEn, .decoderOutput);

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic loadInit();
        for (int i = 0; i < 32; i++) begin
            mem[i] = INIT[4 * i +: 4];
        end
    endtask

    task automatic setRd(input logic [4:0] addr);
        @(negedge clk_sys);
        {wideSelectInput, lookupInput} = addr;
        #1;
    endtask

    task automatic readAll();
        for (int a = 0; a < 32; a++) begin
            setRd(5'(a));
            check(lookupOutputEven, mem[a]);
        end
    endtask

    // cfg fields: enables, polarities, port-enable use, read-only, write expected
    task automatic doWrite(input logic [4:0] addr, input logic [3:0] data, input logic [9:0] cfg);
        logic [3:0] old;
        old = mem[addr];
        {invWriteStrobe, invPortEnableA, invPortEnableB, usePortEnableA, usePortEnableB, romMode} = cfg[6:1];
        // read and write addresses tied bit for bit
        setRd(addr);
        uPart.writeBegin(addr, data, cfg[9:7]);
        // captured but not yet in the array
        check(lookupOutputEven, old);
        check(storageOutputEven, old);
        uPart.writeEnd();
        if (cfg[0]) begin
            mem[addr] = data;
        end
        check(lookupOutputEven, mem[addr]);
    endtask

    initial begin
        {clk_sys, rst_n, wideSelectInput, lookupInput, invClk, readEnable, andOrSel, decInvert} = '0;
        {gateDecWithTri, constLevel, auxNibbleIn, bankReadAddr, triInvert, triDisable, nibbleTriFromDec} = '0;
        {invWriteStrobe, invPortEnableA, invPortEnableB, romMode, modeSel, bufDirCfg} = '0;
        {usePortEnableA, usePortEnableB, leftSideInput, rightSideInput} = {2'h3, 20'h00000};
        cases = '{10'h38D, 10'h18C, 10'h28C, 10'h30C, 10'h201, 10'h07D, 10'h3FC, 10'h38E};
        decTab = '{7'h5B, 7'h52, 7'h73, 7'h04, 7'h07, 7'h20};
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        loadInit();
        readAll();
        // inverted unit clock captures on its falling edge and writes the array on its rising edge
        @(negedge clk_sys);
        invClk = 1'b1;
        repeat (5) @(negedge clk_sys);
        doWrite(5'h00, 4'h5, 10'h38D);
        invClk = 1'b0;
        repeat (5) @(negedge clk_sys);
        // strobe, port enables, polarity and read-only cases
        for (int k = 0; k < 8; k++) begin
            doWrite(5'h1F - 5'(3 * k), ~mem[5'h1F - 5'(3 * k)], cases[k]);
        end
        romMode = 1'b0;
        readAll();
        // a second reset restores the preload and clears the registered copy
        @(negedge clk_sys);
        rst_n = 1'b0;
        #1;
        check(storageOutputEven, 4'h0);
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        loadInit();
        readAll();
        // every mode: buffers pass left to right, decoding groups never drive
        @(negedge clk_sys);
        {bufDirCfg, triDisable, leftSideInput} = {9'h049, 2'h3, 10'h2A5};
        for (int m = 0; m < 8; m++) begin
            @(negedge clk_sys);
            modeSel = 3'(m);
            #1;
            check(rightSideOutputEn, {{2{~modeSel[0]}}, {4{~modeSel[1]}}, {4{~modeSel[2]}}});
            check(leftSideOutputEn, 10'h000);
        end
        @(negedge clk_sys);
        modeSel = 3'h0;
        #1;
        check(rightSideOutput, 10'h2A5);
        @(negedge clk_sys);
        {bufDirCfg, rightSideInput} = {9'h092, 10'h15A};
        #1;
        check(leftSideOutput, 10'h15A);
        check(rightSideOutputEn, 10'h000);
        for (int c = 0; c < 2; c++) begin
            @(negedge clk_sys);
            constLevel = c[0];
            #1;
            check(decoderOutput, constLevel);
        end
        // shared control floats the nibbles only
        @(negedge clk_sys);
        {bufDirCfg, triDisable} = {9'h049, 2'h0};
        #1;
        check(rightSideOutputEn, 10'h300);
        @(negedge clk_sys);
        readEnable = 1'b1;
        #1;
        check(rightSideOutputEn, 10'h3FF);
        @(negedge clk_sys);
        {readEnable, triInvert} = 3'h1;
        #1;
        check(rightSideOutputEn, 10'h30F);
        // stored word driven out from the central input
        @(negedge clk_sys);
        {triInvert, readEnable, bufDirCfg[0], wideSelectInput, lookupInput} = {2'h0, 1'b1, 3'h5, 5'h01};
        #1;
        check(rightSideOutput[3:0], mem[1]);
        // full decode through the and/or gate and inversion
        @(negedge clk_sys);
        {modeSel, wideSelectInput, lookupInput} = {3'h7, 5'h00};
        foreach (decTab[i]) begin
            @(negedge clk_sys);
            {andOrSel, decInvert, bankReadAddr, lookupInput[0]} = decTab[i][6:2];
            auxNibbleIn = {4{decTab[i][1]}};
            #1;
            check(decoderOutput, decTab[i][0]);
        end
        check(rightSideOutputEn, 10'h000);
        // pair decode enables nibble one, shared control keeps nibble zero
        @(negedge clk_sys);
        {modeSel, andOrSel, decInvert, nibbleTriFromDec, bankReadAddr} = {3'h1, 1'b1, 1'b0, 2'h2, 2'h3};
        {lookupInput, readEnable} = {4'h0, 1'b1};
        #1;
        check(rightSideOutputEn, 10'h0FF);
        @(negedge clk_sys);
        bankReadAddr = 2'h0;
        #1;
        check(rightSideOutputEn, 10'h00F);
        @(negedge clk_sys);
        {bankReadAddr, gateDecWithTri, readEnable} = {2'h3, 1'b1, 1'b0};
        #1;
        check(decoderOutput, 1'b0);
        conclude();
    end

    // watchdog: the whole sequence needs only a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        conclude();
    end
endmodule
